//--- core/flash_ctl_map.svh
// Register offsets, field positions, reset values and operation times in ns
// Assumes a 100 MHz system clock and byte addresses on the register bus
`ifndef FLASH_CTL_MAP_SVH
`define FLASH_CTL_MAP_SVH

`define MODE_CTL_OFS 12'h128
`define STATUS_OFS 12'h12c
`define MASK_OFS 12'h130

`define ERASE_BIT 1
`define BULK_BIT 2
`define PROG_BIT 6
`define BURST_BIT 7

`define KEY_READ 8'h96
`define KEY_WRITE 8'ha5

`define ST_AV_BIT 0
`define ST_KV_BIT 1
`define ST_DONE_BIT 2
`define ST_BUSY_BIT 3

`define MODE_RESET 8'h00
`define MASK_RESET 3'h0

`define CLK_PERIOD_NS 10
`define PROG_TIME_NS 50000
`define BURST_TIME_NS 30000
`define SEG_ERASE_TIME_NS 5000000
`define MASS_ERASE_TIME_NS 50000000
`define NS_TO_CYCLES(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- core/flash_ctl_pkg.sv
// Types shared by the flash erase and write controller
// Assumes flash_ctl_map.svh for all numeric constants
package flash_ctl_pkg;

  typedef enum logic [1:0] {
    FSM_IDLE = 2'b01,
    FSM_BUSY = 2'b10
  } fsm_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_PROG = 3'h1,
    OP_BURST = 3'h2,
    OP_SEG = 3'h3,
    OP_MASS = 3'h4
  } op_e;

  typedef struct packed {
    fsm_e fsm;
    op_e op;
    logic erase;
    logic bulk;
    logic prog;
    logic burst;
    logic burst_seg_ok;
    logic [15:0] burst_seg;
    logic [2:0] status;
    logic [2:0] mask;
    logic ap_valid;
    logic ap_write;
    logic [11:0] ap_addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic irq;
    logic start;
    logic busy;
    logic arr_prog;
    logic arr_seg;
    logic arr_mass;
    logic arr_info;
    logic [15:0] arr_addr;
    logic [15:0] arr_data;
  } ctl_state_s;

endpackage

//--- core/flash_erase_write_control.sv
// Flash mode control, operation sequencing and access-violation checks
// Assumes one AHB-Lite master and a flash access port on the same clock
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "flash_ctl_map.svh"

module flash_erase_write_control
  import flash_ctl_pkg::*;
#(
  parameter int SEG_BITS = 9,
  parameter logic [15:0] FLASH_BASE = 16'h1000,
  parameter logic [15:0] MAIN_BASE = 16'h1100,
  parameter int TW = 24,
  parameter int PROG_CYCLES = `NS_TO_CYCLES(`PROG_TIME_NS),
  parameter int BURST_CYCLES = `NS_TO_CYCLES(`BURST_TIME_NS),
  parameter int SEG_ERASE_CYCLES = `NS_TO_CYCLES(`SEG_ERASE_TIME_NS),
  parameter int MASS_ERASE_CYCLES = `NS_TO_CYCLES(`MASS_ERASE_TIME_NS)
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic fa_valid_in,
  input wire logic fa_write_in,
  input wire logic fa_fetch_in,
  input wire logic [15:0] fa_addr_in,
  input wire logic [15:0] fa_wdata_in,
  output logic arr_prog_out,
  output logic arr_seg_erase_out,
  output logic arr_mass_erase_out,
  output logic arr_info_out,
  output logic [15:0] arr_addr_out,
  output logic [15:0] arr_data_out,
  output logic busy_out,
  output logic irq_out
);

  localparam logic [15:0] SEG_MASK = 16'hffff << SEG_BITS;

  // State and timer hookup
  ctl_state_s q;
  ctl_state_s d;
  logic tmr_done;
  logic [TW-1:0] tmr_len;

  // Parameter checks
  generate
    if (SEG_BITS < 1 || SEG_BITS > 15) begin : g_chk_seg
      $error("SEG_BITS out of range");
    end
    if (MAIN_BASE < FLASH_BASE) begin : g_chk_base
      $error("MAIN_BASE below FLASH_BASE");
    end
    if (PROG_CYCLES < 1 || BURST_CYCLES < 1 || SEG_ERASE_CYCLES < 1 ||
        MASS_ERASE_CYCLES < 1) begin : g_chk_len
      $error("Operation lengths must be at least one cycle");
    end
    if (TW < 2 || TW > 32) begin : g_chk_tw
      $error("TW out of range");
    end
    if (PROG_CYCLES >= (64'd1 << TW) || BURST_CYCLES >= (64'd1 << TW) ||
        SEG_ERASE_CYCLES >= (64'd1 << TW) ||
        MASS_ERASE_CYCLES >= (64'd1 << TW)) begin : g_chk_fit
      $error("TW too narrow for operation lengths");
    end
    if (BURST_CYCLES > PROG_CYCLES) begin : g_chk_burst
      $error("Burst programming slower than plain programming");
    end
    if ((FLASH_BASE & ~SEG_MASK) != 16'h0 ||
        (MAIN_BASE & ~SEG_MASK) != 16'h0) begin : g_chk_align
      $error("Flash bases must sit on segment borders");
    end
  endgenerate

  // Read view of one register
  function automatic logic [31:0] read_reg(input ctl_state_s s,
                                            input logic [11:0] a);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      `MODE_CTL_OFS: begin
        r[15:8] = `KEY_READ;
        r[`ERASE_BIT] = s.erase;
        r[`BULK_BIT] = s.bulk;
        r[`PROG_BIT] = s.prog;
        r[`BURST_BIT] = s.burst;
      end
      `STATUS_OFS: begin
        r[2:0] = s.status;
        r[`ST_BUSY_BIT] = s.busy;
      end
      `MASK_OFS: begin
        r[2:0] = s.mask;
      end
      default: begin
        r = 32'h0;
      end
    endcase
    return r;
  endfunction

  // Segment base of a flash address
  function automatic logic [15:0] seg_of(input logic [15:0] a);
    return a & SEG_MASK;
  endfunction

  // Timer length of the running operation
  always_comb begin
    case (q.op)
      OP_PROG: tmr_len = TW'(PROG_CYCLES);
      OP_BURST: tmr_len = TW'(BURST_CYCLES);
      OP_SEG: tmr_len = TW'(SEG_ERASE_CYCLES);
      OP_MASS: tmr_len = TW'(MASS_ERASE_CYCLES);
      default: tmr_len = TW'(1);
    endcase
  end

  // Operation timer
  op_timer #(
    .W(TW)
  ) u_timer (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .start_in(q.start),
    .len_in(tmr_len),
    .done_out(tmr_done)
  );

  // Next state
  always_comb begin
    logic ev_av;
    logic ev_kv;
    logic ev_done;
    logic [2:0] w1c;
    logic in_flash;
    logic in_main;
    logic [3:0] combo;
    logic go;
    op_e go_op;
    ev_av = 1'b0;
    ev_kv = 1'b0;
    ev_done = 1'b0;
    w1c = 3'h0;
    in_flash = fa_addr_in >= FLASH_BASE;
    in_main = fa_addr_in >= MAIN_BASE;
    combo = {q.burst, q.prog, q.bulk, q.erase};
    go = 1'b0;
    go_op = OP_NONE;
    d = q;
    d.start = 1'b0;
    d.hready = 1'b1;
    d.hresp = 1'b0;

    // Operation end and mode self-clear
    if (q.fsm == FSM_BUSY && tmr_done) begin
      d.fsm = FSM_IDLE;
      d.busy = 1'b0;
      d.arr_prog = 1'b0;
      d.arr_seg = 1'b0;
      d.arr_mass = 1'b0;
      d.arr_info = 1'b0;
      ev_done = 1'b1;
      if (q.op == OP_SEG) begin
        d.erase = 1'b0;
      end
      if (q.op == OP_MASS) begin
        d.bulk = 1'b0;
        d.erase = 1'b0;
      end
      d.op = OP_NONE;
    end

    // Register write data phase
    if (q.ap_valid && q.ap_write) begin
      case (q.ap_addr)
        `MODE_CTL_OFS: begin
          // Key first, then busy
          if (hwdata_in[15:8] != `KEY_WRITE) begin
            ev_kv = 1'b1;
          end else if (q.fsm == FSM_BUSY) begin
            ev_av = 1'b1;
          end else begin
            d.erase = hwdata_in[`ERASE_BIT];
            d.bulk = hwdata_in[`BULK_BIT];
            d.prog = hwdata_in[`PROG_BIT];
            d.burst = hwdata_in[`BURST_BIT];
            if (!hwdata_in[`BURST_BIT]) begin
              d.burst_seg_ok = 1'b0;
            end
          end
        end
        `STATUS_OFS: begin
          w1c = hwdata_in[2:0];
        end
        `MASK_OFS: begin
          d.mask = hwdata_in[2:0];
        end
        default: begin
          d.mask = d.mask;
        end
      endcase
    end

    // Flash array accesses
    if (fa_valid_in && in_flash) begin
      // Busy: only fetches pass
      if (q.fsm == FSM_BUSY) begin
        if (fa_write_in || !fa_fetch_in) begin
          ev_av = 1'b1;
        end
      end else if (fa_write_in) begin
        // Mode-bit combination decode
        case (combo)
          4'b0100: begin
            go = 1'b1;
            go_op = OP_PROG;
          end
          4'b1100: begin
            // Burst stays inside one segment
            if (q.burst_seg_ok &&
                seg_of(fa_addr_in) != q.burst_seg) begin
              ev_av = 1'b1;
            end else begin
              go = 1'b1;
              go_op = OP_BURST;
              d.burst_seg_ok = 1'b1;
              d.burst_seg = seg_of(fa_addr_in);
            end
          end
          4'b0001: begin
            go = 1'b1;
            go_op = OP_SEG;
          end
          4'b0010: begin
            // Writes below the main area do nothing
            if (in_main) begin
              go = 1'b1;
              go_op = OP_MASS;
            end
          end
          4'b0011: begin
            go = 1'b1;
            go_op = OP_MASS;
            d.arr_info = 1'b1;
          end
          4'b0000: begin
            ev_av = 1'b1;
          end
          default: begin
            ev_av = 1'b1;
          end
        endcase
      end
    end

    // Operation start
    if (go) begin
      d.fsm = FSM_BUSY;
      d.op = go_op;
      d.start = 1'b1;
      d.busy = 1'b1;
      d.arr_prog = (go_op == OP_PROG) || (go_op == OP_BURST);
      d.arr_seg = go_op == OP_SEG;
      d.arr_mass = go_op == OP_MASS;
      // Array target of the new operation
      if (go_op == OP_SEG) begin
        d.arr_addr = seg_of(fa_addr_in);
        d.arr_data = 16'h0;
      end else if (go_op == OP_MASS) begin
        d.arr_addr = MAIN_BASE;
        d.arr_data = 16'h0;
      end else begin
        d.arr_addr = fa_addr_in;
        d.arr_data = fa_wdata_in;
      end
    end

    // Sticky status, set wins over clear
    d.status = q.status & ~w1c;
    d.status[`ST_AV_BIT] = d.status[`ST_AV_BIT] | ev_av;
    d.status[`ST_KV_BIT] = d.status[`ST_KV_BIT] | ev_kv;
    d.status[`ST_DONE_BIT] = d.status[`ST_DONE_BIT] | ev_done;
    d.irq = |(d.status & d.mask);

    // Register address phase
    d.ap_valid = 1'b0;
    d.ap_write = 1'b0;
    if (hsel_in && htrans_in[1] && hready_in) begin
      d.ap_valid = 1'b1;
      d.ap_write = hwrite_in;
      d.ap_addr = haddr_in[11:0];
      // Read data from next state, a write shows at once
      if (!hwrite_in) begin
        d.hrdata = read_reg(d, haddr_in[11:0]);
      end
    end
  end

  // Clocked state
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      q <= '0;
      q.fsm <= FSM_IDLE;
      q.op <= OP_NONE;
      q.mask <= `MASK_RESET;
      q.hready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign hrdata_out = q.hrdata;
  assign hreadyout_out = q.hready;
  assign hresp_out = q.hresp;
  assign arr_prog_out = q.arr_prog;
  assign arr_seg_erase_out = q.arr_seg;
  assign arr_mass_erase_out = q.arr_mass;
  assign arr_info_out = q.arr_info;
  assign arr_addr_out = q.arr_addr;
  assign arr_data_out = q.arr_data;
  assign busy_out = q.busy;
  assign irq_out = q.irq;

endmodule

//--- core/op_timer.sv
// Down counter that times one array operation
// Assumes a start pulse with a length of at least one cycle
`timescale 1ns/1ps
module op_timer #(
  parameter int W = 24
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire logic [W-1:0] len_in,
  output logic done_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic done;
  } tmr_state_s;

  tmr_state_s q;
  tmr_state_s d;

  generate
    if (W < 2 || W > 32) begin : g_chk
      $error("op_timer width out of range");
    end
  endgenerate

  always_comb begin
    d = q;
    d.done = 1'b0;
    if (start_in) begin
      d.cnt = len_in;
      d.run = 1'b1;
    end else if (q.run) begin
      if (q.cnt <= W'(1)) begin
        d.run = 1'b0;
        d.done = 1'b1;
        d.cnt = '0;
      end else begin
        d.cnt = q.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done_out = q.done;

endmodule

//--- verif/flash_cpu_model.sv
// CPU side of the flash access port
// Does not wait for busy; the bench also calls acc while a program runs
`timescale 1ns/1ps
module flash_cpu_model (
  input wire logic clk_in,
  output logic fa_valid_out,
  output logic fa_write_out,
  output logic fa_fetch_out,
  output logic [15:0] fa_addr_out,
  output logic [15:0] fa_wdata_out
);
  initial begin
    fa_valid_out = 1'b0;
    fa_write_out = 1'b0;
    fa_fetch_out = 1'b0;
    fa_addr_out = 16'h0;
    fa_wdata_out = 16'h0;
  end
  // One-cycle access, lines scrambled afterwards
  task acc(input logic w, input logic f, input logic [15:0] a,
      input logic [15:0] d);
    @(posedge clk_in);
    fa_valid_out <= 1'b1;
    fa_write_out <= w;
    fa_fetch_out <= f;
    fa_addr_out <= a;
    fa_wdata_out <= d;
    @(posedge clk_in);
    fa_valid_out <= 1'b0;
    fa_write_out <= ~w;
    fa_fetch_out <= ~f;
    fa_addr_out <= ~a;
    fa_wdata_out <= ~d;
  endtask
endmodule

//--- verif/flash_ctl_properties.sv
// Checker of the flash array outputs of the controller
// Bound to flash_erase_write_control by the bench top file
`timescale 1ns/1ps
module flash_ctl_properties #(
  parameter logic [15:0] MAIN_BASE = 16'h1100
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic fa_valid_in,
  input wire logic fa_write_in,
  input wire logic [15:0] fa_wdata_in,
  input wire logic arr_prog_out,
  input wire logic arr_seg_erase_out,
  input wire logic arr_mass_erase_out,
  input wire logic [15:0] arr_addr_out,
  input wire logic [15:0] arr_data_out,
  input wire logic busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_start;
    $rose(busy_out);
  endsequence
  sequence s_any_op;
    arr_prog_out || arr_seg_erase_out || arr_mass_erase_out;
  endsequence
  property p_start;
    s_start |-> $past(fa_valid_in && fa_write_in);
  endproperty
  a_start: assert property (p_start)
    else $error("busy rose without a flash write");
  property p_pdata;
    $rose(arr_prog_out) |-> arr_data_out == $past(fa_wdata_in);
  endproperty
  a_pdata: assert property (p_pdata)
    else $error("program data differs from write data");
  property p_sdata;
    arr_seg_erase_out |-> arr_data_out == 16'h0 && arr_addr_out[8:0] == 9'h0;
  endproperty
  a_sdata: assert property (p_sdata)
    else $error("segment erase address or data wrong");
  property p_mass;
    arr_mass_erase_out |-> arr_addr_out == MAIN_BASE;
  endproperty
  a_mass: assert property (p_mass)
    else $error("mass erase address wrong");
  property p_only;
    s_any_op |-> busy_out;
  endproperty
  a_only: assert property (p_only)
    else $error("array operation without busy");
  property p_one;
    $onehot0({arr_prog_out, arr_seg_erase_out, arr_mass_erase_out});
  endproperty
  a_one: assert property (p_one)
    else $error("two array operations at once");
  property p_end;
    $fell(busy_out) |-> !(arr_seg_erase_out || arr_mass_erase_out);
  endproperty
  a_end: assert property (p_end)
    else $error("erase still active after busy fell");
  property p_hold;
    busy_out && $past(busy_out) |-> $stable(arr_addr_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("array address changed during operation");
endmodule

//--- verif/flash_erase_write_control_test.sv
// Self-checking bench of the flash erase and write controller
// Assumes the checker and CPU model are compiled first
`timescale 1ns/1ps
`include "flash_ctl_map.svh"
module flash_erase_write_control_test;
  logic clk_in, nrst_in, hsel_in, hwrite_in;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, q;
  logic [1:0] htrans_in;
  logic [2:0] hsize_in;
  logic hreadyout_out, hresp_out, fa_valid_in, fa_write_in, fa_fetch_in;
  logic [15:0] fa_addr_in, fa_wdata_in, arr_addr_out, arr_data_out;
  logic arr_prog_out, arr_seg_erase_out, arr_mass_erase_out;
  logic arr_info_out, busy_out, irq_out;
  int num_errors = 0, checked = 0, cyc = 0, dur = 0, p = 0;
  flash_erase_write_control #(.PROG_CYCLES(4), .BURST_CYCLES(2),
    .SEG_ERASE_CYCLES(8), .MASS_ERASE_CYCLES(16)) uut (.clk_in, .nrst_in,
    .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
    .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out,
    .hresp_out, .fa_valid_in, .fa_write_in, .fa_fetch_in, .fa_addr_in,
    .fa_wdata_in, .arr_prog_out, .arr_seg_erase_out, .arr_mass_erase_out,
    .arr_info_out, .arr_addr_out, .arr_data_out, .busy_out, .irq_out);
  flash_cpu_model cpu (.clk_in, .fa_valid_out(fa_valid_in),
    .fa_write_out(fa_write_in), .fa_fetch_out(fa_fetch_in),
    .fa_addr_out(fa_addr_in), .fa_wdata_out(fa_wdata_in));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task test_done;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    haddr_in <= {20'h0, a};
    hwrite_in <= w;
    hsize_in <= 3'h2;
    htrans_in <= 2'h2;
    hsel_in <= 1'b1;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    q = hrdata_out;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(q, e);
    chk({hreadyout_out, hresp_out}, 2'b10);
  endtask
  task wbusy;
    dur = 0;
    while (busy_out !== 1'b0 && dur < 200) begin
      @(posedge clk_in);
      #1;
      dur++;
    end
    chk(dur < 200, 1'b1);
  endtask
  // Mode set, one flash write, outputs, status and mode after
  task flw(input logic [7:0] m, input logic [15:0] a, input logic [3:0] v,
      input logic [15:0] ea, input logic [2:0] st, input logic [7:0] ma);
    wr(`MODE_CTL_OFS, {16'h0, `KEY_WRITE, m});
    cpu.acc(1'b1, 1'b0, a, 16'h5a5a);
    #1;
    chk({arr_prog_out, arr_seg_erase_out, arr_mass_erase_out,
      arr_info_out}, v);
    if (v != 0) chk({arr_addr_out, arr_data_out},
      {ea, v[3] ? 16'h5a5a : 16'h0});
    @(posedge clk_in);
    wbusy;
    rd(`STATUS_OFS, st);
    chk(irq_out, st != 0);
    rd(`MODE_CTL_OFS, {`KEY_READ, ma});
    wr(`STATUS_OFS, 32'h7);
  endtask
  task t_regs;
    rd(`MODE_CTL_OFS, {`KEY_READ, `MODE_RESET});
    rd(`STATUS_OFS, 32'h0);
    rd(`MASK_OFS, 32'h0);
    rd(12'h200, 32'h0);
  endtask
  task t_key;
    wr(`MODE_CTL_OFS, 32'h0042);
    rd(`MODE_CTL_OFS, {`KEY_READ, 8'h0});
    rd(`STATUS_OFS, 32'h2);
    chk(irq_out, 1'b0);
    wr(`MASK_OFS, 32'h7);
    repeat (2) @(posedge clk_in);
    chk(irq_out, 1'b1);
    wr(`STATUS_OFS, 32'h7);
    repeat (2) @(posedge clk_in);
    chk(irq_out, 1'b0);
  endtask
  task t_ops;
    flw(8'h40, 16'h1102, 4'h8, 16'h1102, 3'h4, 8'h40);
    p = dur;
    flw(8'hc0, 16'h1200, 4'h8, 16'h1200, 3'h4, 8'hc0);
    flw(8'hc0, 16'h1202, 4'h8, 16'h1202, 3'h4, 8'hc0);
    chk(p - dur, 2);
    flw(8'hc0, 16'h1400, 4'h0, 16'h0, 3'h1, 8'hc0);
    flw(8'h40, 16'h1600, 4'h8, 16'h1600, 3'h4, 8'h40);
    flw(8'hc0, 16'h1400, 4'h8, 16'h1400, 3'h4, 8'hc0);
    flw(8'h00, 16'h1104, 4'h0, 16'h0, 3'h1, 8'h00);
    flw(8'h02, 16'h1234, 4'h4, 16'h1200, 3'h4, 8'h00);
    flw(8'h04, 16'h1010, 4'h0, 16'h0, 3'h0, 8'h04);
    flw(8'h04, 16'h1400, 4'h2, 16'h1100, 3'h4, 8'h00);
    flw(8'h06, 16'h1010, 4'h3, 16'h1100, 3'h4, 8'h00);
    flw(8'hc2, 16'h1200, 4'h0, 16'h0, 3'h1, 8'hc2);
  endtask
  // Second access while a program runs
  task t_busy(input logic f, input logic [2:0] st);
    wr(`MODE_CTL_OFS, {16'h0, `KEY_WRITE, 8'h40});
    cpu.acc(1'b1, 1'b0, 16'h1100, 16'h0001);
    cpu.acc(~f, f, 16'h1180, 16'h0);
    wbusy;
    rd(`STATUS_OFS, st);
    wr(`STATUS_OFS, 32'h7);
  endtask
  initial begin
    nrst_in = 1'b0;
    hsel_in = 1'b0;
    haddr_in = 32'h0;
    htrans_in = 2'h0;
    hwrite_in = 1'b0;
    hsize_in = 3'h2;
    hwdata_in = 32'h0;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_regs;
    t_key;
    t_ops;
    t_busy(1'b1, 3'h4);
    t_busy(1'b0, 3'h5);
    test_done;
  end
endmodule
bind flash_erase_write_control flash_ctl_properties #(.MAIN_BASE(MAIN_BASE))
  props (.clk_in, .nrst_in, .fa_valid_in, .fa_write_in, .fa_wdata_in,
  .arr_prog_out, .arr_seg_erase_out, .arr_mass_erase_out, .arr_addr_out,
  .arr_data_out, .busy_out);
